// >>> common/pt_pkg.sv
package pt_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int PT_NUM_TIMERS = 5;   // Five timers, the last one is the watchdog.
  localparam int PT_DATA_W = 32;      // Timer counter and bus data width.
  localparam int PT_PRESC_W = 16;     // Shared prescaler width.
  localparam int PT_ADDR_W = 8;       // Byte address width of the register window.
  localparam int PT_WDOG_IDX = 4;     // Index of the watchdog timer.

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PT_OFS_PRESC_VAL = 8'h00;  // Prescaler current value, read only.
  localparam logic [7:0] PT_OFS_PRESC_RLD = 8'h04;  // Prescaler reload value.
  localparam logic [7:0] PT_OFS_IRQ_STAT = 8'h08;   // Sticky underflow status, write one to clear.
  localparam logic [7:0] PT_OFS_IRQ_MASK = 8'h0C;   // Interrupt mask, same layout as status.
  localparam logic [3:0] PT_TMR_BLOCK_FIRST = 4'h1; // Timer n sits in 16-byte block n+1.
  localparam logic [1:0] PT_SUB_COUNT = 2'h0;       // Word 0 of a timer block: counter.
  localparam logic [1:0] PT_SUB_RELOAD = 2'h1;      // Word 1 of a timer block: reload.
  localparam logic [1:0] PT_SUB_CTRL = 2'h2;        // Word 2 of a timer block: control.

  // ---------------------------------------------------------------
  // Control field positions and reset values
  // ---------------------------------------------------------------
  localparam int PT_CTRL_EN_BIT = 0;       // Enable bit.
  localparam int PT_CTRL_RESTART_BIT = 1;  // Restart (auto reload) bit.
  localparam int PT_CTRL_CHAIN_BIT = 2;    // Chain to previous timer bit.
  localparam logic [15:0] PT_PRESC_RLD_RST = 16'h0063;  // Reload value after reset.
  localparam logic [31:0] PT_RELOAD_RST = 32'h0000_0000; // Timer reload after reset.
  localparam logic [31:0] PT_WDOG_RELOAD_RST = 32'h0000_FFFF; // Watchdog reload after reset.
  localparam logic [31:0] PT_COUNT_RST = 32'h0000_0000;  // Timer counter after reset.

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic chain;    // Count on previous timer underflow instead of tick.
    logic restart;  // Reload on underflow instead of stopping.
    logic en;       // Timer counts while set.
  } pt_ctrl_s;

  typedef struct packed {
    logic wrCount;   // Write strobe for the counter.
    logic wrReload;  // Write strobe for the reload value.
    logic wrCtrl;    // Write strobe for the control word.
  } pt_wr_s;

  typedef enum logic [1:0] {
    PT_ST_SYNC = 2'b00,    // Strap synchroniser is filling.
    PT_ST_SETTLE = 2'b01,  // Second synchroniser stage is filling.
    PT_ST_LOAD = 2'b10,    // Strap is valid, watchdog enable is loaded.
    PT_ST_RUN = 2'b11      // Normal operation.
  } pt_strap_e;

  // Merges new bus data into an old word under the byte enables.
  function automatic logic [31:0] ptMergeBytes(input logic [31:0] oldVal,
                                               input logic [31:0] newVal,
                                               input logic [3:0] be);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

// >>> logic/pt_timer_chan.sv
`timescale 1ns/1ps
// One down-counting timer with its reload value and control word.
module pt_timer_chan import pt_pkg::*; #(
  parameter logic [31:0] RELOAD_RST = PT_RELOAD_RST
) (
  input wire logic core_clk,           // System clock.
  input wire logic rst_n,              // Asynchronous reset, active low.
  input wire logic tick,               // Prescaler tick, one-cycle pulse.
  input wire logic prevUnder,          // Underflow pulse of the previous timer.
  input wire pt_wr_s wr,               // Register write strobes.
  input wire logic [31:0] wrData,      // Bus write data.
  input wire logic [3:0] wrBe,         // Bus byte enables.
  input wire logic strapLoad,          // Load strapped enable and reload once.
  input wire logic strapEn,            // Strapped enable value.
  output logic [31:0] count,           // Current counter value.
  output logic [31:0] reload,          // Reload value.
  output pt_ctrl_s ctrl,               // Control word.
  output logic under                   // Underflow pulse, one cycle.
);

  logic [31:0] next_count;  // Next counter value.
  logic [31:0] next_reload; // Next reload value.
  pt_ctrl_s next_ctrl;      // Next control word.
  logic next_under;         // Next underflow pulse.
  logic step;               // Counter steps this cycle.
  logic [31:0] ctrlMerged;  // Control word after byte merge.

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // A bus write lands after the count update, so software wins a collision.
  always_comb begin
    next_count = count;
    next_reload = reload;
    next_ctrl = ctrl;
    next_under = 1'b0;
    ctrlMerged = ptMergeBytes({29'h0, ctrl}, wrData, wrBe);
    step = ctrl.en && (ctrl.chain ? prevUnder : tick); // [R4] [R5] [R9]
    if (step) begin
      if (count == 32'h0000_0000) begin
        next_under = 1'b1; // [R8]
        if (ctrl.restart) begin
          next_count = reload; // [R6]
        end else begin
          next_count = 32'hFFFF_FFFF; // [R7]
          next_ctrl.en = 1'b0; // [R7]
        end
      end else begin
        next_count = count - 32'h0000_0001; // [R5]
      end
    end
    if (wr.wrReload) begin
      next_reload = ptMergeBytes(reload, wrData, wrBe);
    end
    if (wr.wrCount) begin
      next_count = ptMergeBytes(count, wrData, wrBe);
    end
    if (wr.wrCtrl) begin
      next_ctrl.en = ctrlMerged[PT_CTRL_EN_BIT]; // [R4]
      next_ctrl.restart = ctrlMerged[PT_CTRL_RESTART_BIT];
      next_ctrl.chain = ctrlMerged[PT_CTRL_CHAIN_BIT];
    end
    if (strapLoad) begin
      next_ctrl.en = strapEn; // [R12]
      next_count = reload;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= PT_COUNT_RST;
      reload <= RELOAD_RST;
      ctrl <= '0;
      under <= 1'b0;
    end else begin
      count <= next_count;
      reload <= next_reload;
      ctrl <= next_ctrl;
      under <= next_under;
    end
  end

endmodule

// >>> logic/pt_timer_unit.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// How it works
// (R1) Shared 16-bit prescaler decrements every clock.
// (R2) Prescaler underflow reloads it and emits tick.
// (R3) Five independent 32-bit down-counting timers.
// (R4) Timer counts only while enable bit set.
// (R5) Unchained timer decrements once per tick.
// (R6) Underflow with restart reloads from reload value.
// (R7) Underflow without restart: stays -1, enable cleared.
// (R8) Timer underflow can raise an interrupt.
// (R9) Chained timer counts on previous timer underflow.
// (R10) Each non-watchdog timer has its own line.
// (R11) Last timer drives watchdog output on underflow.
// (R12) Watchdog enable after reset follows boot-memory strap.
// (R13) All values reachable over the register bus.
// (R14) Counter reads never disturb counting.
// ---------------------------------------------------------------
module pt_timer_unit import pt_pkg::*; #(
  parameter int NUM_TIMERS = PT_NUM_TIMERS,         // Number of timers.
  parameter logic [15:0] PRESC_RLD_RST = PT_PRESC_RLD_RST, // Prescaler reload after reset.
  parameter logic [31:0] WDOG_RELOAD_RST = PT_WDOG_RELOAD_RST // Watchdog reload after reset.
) (
  input wire logic core_clk,                 // System clock, 100 MHz.
  input wire logic rst_n,                    // Asynchronous reset, active low.
  input wire logic [7:0] avs_address,        // Avalon byte address.
  input wire logic avs_read,                 // Avalon read request.
  input wire logic avs_write,                // Avalon write request.
  input wire logic [31:0] avs_writedata,     // Avalon write data.
  input wire logic [3:0] avs_byteenable,     // Avalon byte enables.
  output logic [31:0] avs_readdata,          // Avalon read data.
  output logic avs_waitrequest,              // Avalon wait request.
  input wire logic bootMemPresent,           // Boot memory present strap, asynchronous.
  output logic [3:0] timerIrq,               // Per-timer interrupt lines.
  output logic irq,                          // Combined interrupt, level.
  output logic wdogOut                       // Watchdog expiry, level until cleared.
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic bootSync1;                 // First synchroniser stage.
  logic bootSync2;                 // Second synchroniser stage.
  pt_strap_e strapState;           // Strap capture state.
  pt_strap_e next_strapState;      // Next strap state.
  logic strapLoad;                 // Load strap into the watchdog this cycle.
  logic [15:0] prescVal;           // Prescaler counter.
  logic [15:0] next_prescVal;      // Next prescaler counter.
  logic [15:0] prescReload;        // Prescaler reload value.
  logic [15:0] next_prescReload;   // Next prescaler reload value.
  logic tick;                      // Prescaler tick pulse.
  logic next_tick;                 // Next tick pulse.
  logic [4:0] irqStat;             // Sticky underflow status.
  logic [4:0] next_irqStat;        // Next status.
  logic [4:0] irqMask;             // Interrupt mask.
  logic [4:0] next_irqMask;        // Next mask.
  logic [3:0] next_timerIrq;       // Next per-timer lines.
  logic next_irq;                  // Next combined interrupt.
  logic next_wdogOut;              // Next watchdog output.
  logic next_waitrequest;          // Next wait request.
  logic [31:0] next_readdata;      // Next read data.
  logic [31:0] readMux;            // Read data for the current address.
  logic [31:0] prescMerged;        // Prescaler reload after a byte-lane merge.
  logic [31:0] statClrBits;        // Write-one-to-clear bits of a status write.
  logic [31:0] maskMerged;         // Mask after a byte-lane merge.
  logic wrEn;                      // A write completes this cycle.
  logic tmrHit;                    // Address falls in a timer block.
  logic [3:0] tmrSel;              // Selected timer index.
  logic [31:0] chanCount [NUM_TIMERS];  // Counter of each timer.
  logic [31:0] chanReload [NUM_TIMERS]; // Reload of each timer.
  pt_ctrl_s chanCtrl [NUM_TIMERS];      // Control of each timer.
  logic [NUM_TIMERS-1:0] under;         // Underflow pulses.
  pt_wr_s chanWr [NUM_TIMERS];          // Write strobes per timer.
  logic [NUM_TIMERS-1:0] prevUnder;     // Chain inputs per timer.

  // ---------------------------------------------------------------
  // Strap synchroniser
  // ---------------------------------------------------------------
  // The strap is a pin, so it crosses two flops before anything reads it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bootSync1 <= 1'b0;
      bootSync2 <= 1'b0;
    end else begin
      bootSync1 <= bootMemPresent;
      bootSync2 <= bootSync1;
    end
  end

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  // Async reset may only load constants, so the strap is sampled once the
  // synchroniser has filled, two edges after release.
  always_comb begin
    strapLoad = 1'b0;
    case (strapState)
      PT_ST_SYNC: begin
        next_strapState = PT_ST_SETTLE;
      end
      PT_ST_SETTLE: begin
        next_strapState = PT_ST_LOAD;
      end
      PT_ST_LOAD: begin
        strapLoad = 1'b1; // [R12]
        next_strapState = PT_ST_RUN;
      end
      PT_ST_RUN: begin
        next_strapState = PT_ST_RUN;
      end
      default: begin
        next_strapState = PT_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapState <= PT_ST_SYNC;
    end else begin
      strapState <= next_strapState;
    end
  end

  // ---------------------------------------------------------------
  // Address decode and read mux
  // ---------------------------------------------------------------
  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    tmrSel = avs_address[7:4] - PT_TMR_BLOCK_FIRST;
    tmrHit = (avs_address[7:4] != 4'h0) && (tmrSel < 4'(NUM_TIMERS));
    wrEn = avs_write && !avs_waitrequest; // [R13]
    readMux = 32'h0000_0000;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      chanWr[i] = '0;
      if (tmrHit && (tmrSel == 4'(i)) && wrEn) begin
        chanWr[i].wrCount = (avs_address[3:2] == PT_SUB_COUNT);
        chanWr[i].wrReload = (avs_address[3:2] == PT_SUB_RELOAD);
        chanWr[i].wrCtrl = (avs_address[3:2] == PT_SUB_CTRL);
      end
    end
    if (tmrHit) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (tmrSel == 4'(i)) begin
          case (avs_address[3:2])
            PT_SUB_COUNT: readMux = chanCount[i]; // [R14]
            PT_SUB_RELOAD: readMux = chanReload[i];
            PT_SUB_CTRL: readMux = {29'h0, chanCtrl[i]};
            default: readMux = 32'h0000_0000;
          endcase
        end
      end
    end else begin
      case (avs_address)
        PT_OFS_PRESC_VAL: readMux = {16'h0, prescVal};
        PT_OFS_PRESC_RLD: readMux = {16'h0, prescReload};
        PT_OFS_IRQ_STAT: readMux = {27'h0, irqStat};
        PT_OFS_IRQ_MASK: readMux = {27'h0, irqMask};
        default: readMux = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait state: the request is seen, then waitrequest drops for one
  // cycle with read data already registered.
  always_comb begin
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest); // [R13]
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_readdata = readMux; // [R13]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler, status, mask and outputs
  // ---------------------------------------------------------------
  // Hardware set wins over a write-one clear in the same cycle.
  always_comb begin
    next_prescReload = prescReload;
    next_irqMask = irqMask;
    next_tick = 1'b0;
    // Merged words are formed first, since a call result cannot be sliced.
    prescMerged = ptMergeBytes({16'h0, prescReload}, avs_writedata, avs_byteenable);
    statClrBits = ptMergeBytes(32'h0, avs_writedata, avs_byteenable);
    maskMerged = ptMergeBytes({27'h0, irqMask}, avs_writedata, avs_byteenable);
    if (prescVal == 16'h0000) begin
      next_prescVal = prescReload; // [R2]
      next_tick = 1'b1; // [R2]
    end else begin
      next_prescVal = prescVal - 16'h0001; // [R1]
    end
    next_irqStat = irqStat;
    if (wrEn && !tmrHit) begin
      case (avs_address)
        PT_OFS_PRESC_RLD: next_prescReload = prescMerged[15:0];
        PT_OFS_IRQ_STAT: next_irqStat = irqStat & ~statClrBits[4:0];
        PT_OFS_IRQ_MASK: next_irqMask = maskMerged[4:0];
        default: next_irqMask = irqMask;
      endcase
    end
    next_irqStat = next_irqStat | under; // [R8]
    next_timerIrq = next_irqStat[3:0] & next_irqMask[3:0]; // [R10]
    next_irq = |(next_irqStat & next_irqMask); // [R8]
    next_wdogOut = next_irqStat[PT_WDOG_IDX]; // [R11]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescVal <= 16'h0000;
      prescReload <= PRESC_RLD_RST;
      tick <= 1'b0;
      irqStat <= 5'h00;
      irqMask <= 5'h00;
      timerIrq <= 4'h0;
      irq <= 1'b0;
      wdogOut <= 1'b0;
    end else begin
      prescVal <= next_prescVal;
      prescReload <= next_prescReload;
      tick <= next_tick;
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      timerIrq <= next_timerIrq;
      irq <= next_irq;
      wdogOut <= next_wdogOut;
    end
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  // Timer 0 has no predecessor, so its chain input is the tick itself.
  always_comb begin
    prevUnder = {under[NUM_TIMERS-2:0], tick}; // [R9]
  end

  for (genvar g = 0; g < NUM_TIMERS; g++) begin : gTimer
    pt_timer_chan #(
      .RELOAD_RST((g == PT_WDOG_IDX) ? WDOG_RELOAD_RST : PT_RELOAD_RST)
    ) uChan ( // [R3]
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tick),
      .prevUnder(prevUnder[g]),
      .wr(chanWr[g]),
      .wrData(avs_writedata),
      .wrBe(avs_byteenable),
      .strapLoad(strapLoad && (g == PT_WDOG_IDX)),
      .strapEn(bootSync2),
      .count(chanCount[g]),
      .reload(chanReload[g]),
      .ctrl(chanCtrl[g]),
      .under(under[g])
    );
  end

endmodule

// >>> verif/pt_timer_unit_asserts.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port-side checks of the timer unit: bus handshake and interrupts.
// ---------------------------------------------------------------
module pt_timer_unit_asserts (
  input wire logic core_clk,             // System clock.
  input wire logic rst_n,                // Asynchronous reset, active low.
  input wire logic [7:0] avs_address,    // Byte address.
  input wire logic avs_read,             // Read request.
  input wire logic avs_write,            // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte enables.
  input wire logic [31:0] avs_readdata,  // Read data.
  input wire logic avs_waitrequest,      // Wait request.
  input wire logic bootMemPresent,       // Boot memory strap.
  input wire logic [3:0] timerIrq,       // Per-timer lines.
  input wire logic irq,                  // Combined interrupt.
  input wire logic wdogOut               // Watchdog output.
);
  // All checks share one clock, and reset silences them.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A taken request is answered after exactly one wait state.
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_no_spurious: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  // Unmapped space reads as zero; narrow registers read zero above their width.
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address >= 8'h60
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_presc_width: assert property (avs_read && avs_waitrequest && avs_address == 8'h00
    |=> avs_readdata[31:16] == 16'h0000)
    else $error("prescaler wider than 16 bits");
  chk_ctrl_width: assert property (avs_read && avs_waitrequest && avs_address[3:0] == 4'h8
    && avs_address[7:4] >= 4'h1 && avs_address[7:4] <= 4'h5 |=> avs_readdata[31:3] == 29'h0)
    else $error("control word has stray bits");
  // Read data must not wander between reads, or counting would show through.
  chk_rdata_hold: assert property (!$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  chk_irq_covers: assert property (|timerIrq |-> irq)
    else $error("timer line high without combined interrupt");
  // Sticky outputs only drop on a software write.
  chk_wdog_clear: assert property ($fell(wdogOut) |-> $past(avs_write))
    else $error("watchdog output dropped without a write");
  chk_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
    else $error("interrupt dropped without a write");
endmodule

bind pt_timer_unit pt_timer_unit_asserts i_pt_timer_unit_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .bootMemPresent(bootMemPresent), .timerIrq(timerIrq), .irq(irq), .wdogOut(wdogOut)
);

// >>> verif/pt_timer_unit_bench.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Self-checking bench; short reload values keep the run brief.
// ---------------------------------------------------------------
module pt_timer_unit_bench import pt_pkg::*;;
  localparam logic [15:0] PRESC = 16'h0007;       // Tick every eight cycles.
  localparam logic [31:0] WDRLD = 32'h0000_0010;  // Short watchdog period.
  localparam int PER = 8;                         // Cycles per tick.
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, bootMemPresent, irq, wdogOut;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed, rd, rl, c;
  logic [3:0] avs_byteenable, timerIrq;
  logic [4:0] evv;  // Watchdog and timer lines side by side.
  int nErrors, numChecks, t;

  assign evv = {wdogOut, timerIrq};

  pt_timer_unit #(.PRESC_RLD_RST(PRESC), .WDOG_RELOAD_RST(WDRLD)) i_pt_timer_unit (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bootMemPresent(bootMemPresent), .timerIrq(timerIrq), .irq(irq), .wdogOut(wdogOut));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Repeatable pseudo-random source.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Byte-lane merge of a write, worked out independently of the design.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction

  task automatic reportAndStop();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus access; the request stands until waitrequest is sampled low.
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      check("busTimeout", 0, 1);
      reportAndStop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  // Bounded wait for an interrupt line, counting cycles.
  task automatic waitEv(input int b, input int lim, output int cyc);
    cyc = 0;
    while (evv[b] !== 1'b1) begin
      @(posedge core_clk);
      cyc++;
      if (cyc > lim) begin
        check("eventTimeout", b, 32'hFF);
        reportAndStop();
      end
    end
  endtask

  task automatic doReset(input logic boot);
    bootMemPresent <= boot;
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  initial begin
    {rst_n, avs_read, avs_write, bootMemPresent} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    seed = 32'd37;
    nErrors = 0;
    numChecks = 0;
    doReset(1'b0);
    // Reset state, unmapped space and the strap-off watchdog.
    bus(0, 8'h04, 0, 0, rd); check("prescReload", rd, {16'h0, PRESC});
    bus(0, 8'h08, 0, 0, rd); check("status", rd, 32'h0);
    bus(0, 8'h58, 0, 0, rd); check("wdogCtrlOff", rd, 32'h0);
    bus(0, 8'h54, 0, 0, rd); check("wdogReload", rd, WDRLD);
    wr(8'h80, seed);
    bus(0, 8'h80, 0, 0, rd); check("unmapped", rd, 32'h0);
    bus(0, 8'h00, 0, 0, rd); check("prescRange", rd[15:0] <= PRESC, 1);
    $display("test reset done");
    // Random words on a disabled timer: full width, byte merge, no counting.
    rl = 32'h0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      c = lfsr(seed);
      wr(8'h40, seed);
      bus(1, 8'h44, c, seed[3:0], rd);
      rl = merge(rl, c, seed[3:0]);
      repeat (3 * PER) @(posedge core_clk);
      bus(0, 8'h40, 0, 0, rd); check("holdCount", rd, seed);
      bus(0, 8'h44, 0, 0, rd); check("reloadMerge", rd, rl);
    end
    // A random reload may be taken at an underflow; keep it short and let it drain.
    wr(8'h04, {24'h0, seed[7:0]});
    bus(0, 8'h04, 0, 0, rd); check("prescWrite", rd, {24'h0, seed[7:0]});
    wr(8'h04, {16'h0, PRESC});
    repeat (270) @(posedge core_clk);
    $display("test registers done");
    // One-shot timer 0: period, stop at all ones, sticky status and mask.
    c = (seed & 32'h0000_000F) + 32'd2;
    wr(8'h0C, 32'h1F);
    wr(8'h10, c);
    wr(8'h18, 32'h1);
    waitEv(0, 400, t);
    check("oneShotTime", t >= c * PER && t <= (c + 2) * PER + 4, 1);
    check("ownLine", timerIrq, 4'h1);
    check("irqRaised", irq, 1'b1);
    bus(0, 8'h10, 0, 0, rd); check("stopAtOnes", rd, 32'hFFFF_FFFF);
    bus(0, 8'h18, 0, 0, rd); check("enCleared", rd, 32'h0);
    wr(8'h08, 32'h1);
    @(posedge core_clk);
    check("irqCleared", {timerIrq, irq}, 5'h0);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h2);
    wr(8'h18, 32'h1);
    repeat (6 * PER) @(posedge core_clk);
    bus(0, 8'h08, 0, 0, rd); check("statusMasked", rd, 32'h1);
    check("irqMasked", irq, 1'b0);
    wr(8'h08, 32'h1F);
    wr(8'h0C, 32'h1F);
    $display("test oneshot done");
    // Timer 1 restarts with reload 1; timer 2 counts its underflows.
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h1);
    wr(8'h30, 32'h2);
    wr(8'h38, 32'h5);
    wr(8'h28, 32'h3);
    waitEv(2, 200, t);
    check("chainTime", t >= 5 * PER && t <= 7 * PER + 6, 1);
    bus(0, 8'h28, 0, 0, rd); check("restartEn", rd, 32'h3);
    bus(0, 8'h20, 0, 0, rd); check("restartCount", rd <= 32'h1, 1);
    bus(0, 8'h30, 0, 0, rd); check("chainStop", rd, 32'hFFFF_FFFF);
    wr(8'h28, 32'h0);
    wr(8'h08, 32'h1F);
    $display("test chain done");
    // Watchdog enabled by the strap runs out on its own.
    doReset(1'b1);
    bus(0, 8'h58, 0, 0, rd); check("wdogCtrlOn", rd, 32'h1);
    waitEv(4, 400, t);
    check("wdogTime", t <= (WDRLD + 2) * PER, 1);
    check("wdogNotShared", {timerIrq, irq}, 5'h0);
    bus(0, 8'h50, 0, 0, rd); check("wdogStop", rd, 32'hFFFF_FFFF);
    wr(8'h08, 32'h10);
    @(posedge core_clk);
    check("wdogCleared", wdogOut, 1'b0);
    $display("test watchdog done");
    reportAndStop();
  end
endmodule
